// File: src/lwsp_pkg.sv
// Package: constants and types for the late-write synchronous RAM port
package lwsp_pkg;
  localparam int ADDR_W  = 10;
  localparam int LANES   = 4;
  localparam int LANE_W  = 9;
  localparam int DATA_W  = LANES * LANE_W;
  localparam int DEPTH   = 1 << ADDR_W;
  localparam int PIPE_LAT = 2;
  localparam int SLEEP_DLY = 2;
  localparam logic [1:0] SLEEP_CNT_INIT = 2'h0;
  localparam logic [1:0] BURST_INIT     = 2'h0;
  localparam logic [1:0] BURST_ONE      = 2'h1;

  typedef enum logic [1:0] {LWSP_IDLE, LWSP_RD, LWSP_WR, LWSP_DESEL} lwsp_burst_t;

  // Next burst offset from start offset and step count
  function automatic logic [1:0] lwsp_burst_addr(input logic [1:0] start,
                                                 input logic [1:0] step,
                                                 input logic       interleave);
    lwsp_burst_addr = interleave ? (start ^ step) : (start + step);
  endfunction : lwsp_burst_addr
endpackage : lwsp_pkg

// File: src/lwsp_sync3.sv
// Three-stage synchroniser with agreement of the last two stages
module lwsp_sync3
  import lwsp_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } lwsp_sync_t;

  lwsp_sync_t st_ff;
  lwsp_sync_t nxt_st;

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.s1  = i_async;
    nxt_st.s2  = st_ff.s1;
    nxt_st.s3  = st_ff.s2;
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.lvl = st_ff.s3;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_level = st_ff.lvl;
endmodule : lwsp_sync3

// File: src/lwsp_port.sv
// Top: command decode, burst counter, late-write pipes and data drivers
// Notes on behaviour
// [RL1] Clock gate high freezes all state except the sleep counter and asleep flag; the sleep synchroniser also runs and zz_hold clears rd_vld
// [RL2] Sample synchronous inputs on rising edges
// [RL3] Controller loads new address with load low
// [RL4] Select needs sel_lo_a, sel_lo_c low, sel_hi high
// [RL5] Selected load with write high starts read
// [RL6] Pipelined read data leaves output register
// [RL7] Selected load with write low registers write
// [RL8] Each low lane enable writes its byte
// [RL9] No lanes enabled aborts write, bus floats
// [RL10] Pipelined write data two cycles after command
// [RL11] Flow-through read data one cycle sooner
// [RL12] Flow-through write data one cycle after command
// [RL13] Load high continues burst with next address
// [RL14] Continued deselect only after a deselect
// [RL15] Two-bit counter steps on every continue after a load
// [RL16] Output enable high makes dummy read
// [RL17] Drivers off during write cycles
// [RL18] Gated clock keeps read bus, write floats
// [RL19] Outputs float until first command
// [RL20] Order select picks linear or interleaved
// [RL21] Flow-through when mode select is low
// [RL22] Sleep two cycles after request, outputs float
// [RL23] Order and mode are static configuration
module lwsp_port
  import lwsp_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire logic              i_clk_gate_n,
  input  wire logic              i_chip_sel_lo_a,
  input  wire logic              i_chip_sel_hi,
  input  wire logic              i_chip_sel_lo_c,
  input  wire logic              i_write_n,
  input  wire logic [LANES-1:0]  i_byte_lane_n,
  input  wire logic              i_burst_step_load,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_out_en_n,
  input  wire logic              i_linear_order_n,
  input  wire logic              i_flowthru_sel_n,
  input  wire logic              i_sleep_req,
  input  wire logic [DATA_W-1:0] i_dq,
  output logic      [DATA_W-1:0] o_dq,
  output logic                   o_dq_oe,
  output logic                   o_asleep
);
  // Pipeline slot for a registered access
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [LANES-1:0]  lanes_n;
    logic [ADDR_W-1:0] addr;
  } lwsp_slot_t;

  typedef struct packed {
    lwsp_burst_t       burst;
    logic [ADDR_W-1:0] base;
    logic [1:0]        step;
    lwsp_slot_t        s1;
    lwsp_slot_t        s2;
    logic [DATA_W-1:0] rd_reg;
    logic              rd_vld;
    logic              started;
    logic [1:0]        zz_cnt;
    logic              asleep;
  } lwsp_state_t;

  lwsp_state_t st_ff;
  lwsp_state_t nxt_st;
  logic [DATA_W-1:0] mem_ff [DEPTH];

  logic zz_sync;
  lwsp_sync3 u_zz_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   (i_sleep_req),
    .o_level   (zz_sync)
  );

  logic              flow;
  logic              selected;
  logic              is_load;
  logic              is_cont;
  logic              cont_ok;
  logic [ADDR_W-1:0] cur_addr;
  lwsp_slot_t        wr_slot;
  logic [DATA_W-1:0] rd_word;
  logic              zz_hold;
  logic              frozen;

  assign flow     = ~i_flowthru_sel_n;                                 // RL21 RL23
  assign selected = ~i_chip_sel_lo_a & i_chip_sel_hi & ~i_chip_sel_lo_c; // RL4
  assign is_load  = ~i_burst_step_load;                                 // RL3
  assign is_cont  = i_burst_step_load;                                  // RL13
  assign cont_ok  = is_cont & (st_ff.burst != LWSP_IDLE);               // RL14
  assign zz_hold  = zz_sync | st_ff.asleep;
  assign frozen   = i_clk_gate_n | st_ff.asleep;                        // RL1 RL22

  // Current burst address: base high bits with stepped low two bits
  assign cur_addr = {st_ff.base[ADDR_W-1:2],
                     lwsp_burst_addr(st_ff.base[1:0], st_ff.step,
                                     i_linear_order_n)};               // RL20

  // Writes land from the slot whose data is due this edge
  assign wr_slot = flow ? st_ff.s1 : st_ff.s2;                          // RL10 RL12

  always_comb begin
    nxt_st = st_ff;
    // Sleep entry counts regardless of clock gate; wake drops back at once
    if (zz_sync) begin
      if (st_ff.zz_cnt != SLEEP_DLY[1:0]) begin
        nxt_st.zz_cnt = st_ff.zz_cnt + BURST_ONE;
      end
      nxt_st.asleep = (st_ff.zz_cnt + BURST_ONE) >= SLEEP_DLY[1:0];    // RL22
    end else begin
      nxt_st.zz_cnt = SLEEP_CNT_INIT;
      nxt_st.asleep = 1'b0;
    end
    if (!frozen) begin                                                  // RL1 RL2
      nxt_st.s2     = st_ff.s1;
      nxt_st.s1     = '0;
      nxt_st.rd_vld = 1'b0;
      if (is_load) begin
        nxt_st.step = BURST_INIT;
        nxt_st.base = i_addr;
        if (!selected) begin
          nxt_st.burst = LWSP_DESEL;                                    // RL4
        end else if (i_write_n) begin
          nxt_st.burst   = LWSP_RD;                                     // RL5
          nxt_st.s1.rd   = 1'b1;
          nxt_st.s1.addr = i_addr;
          nxt_st.started = 1'b1;
        end else begin
          nxt_st.burst      = LWSP_WR;                                  // RL7
          nxt_st.s1.wr      = ~&i_byte_lane_n;                          // RL9
          nxt_st.s1.lanes_n = i_byte_lane_n;
          nxt_st.s1.addr    = i_addr;
          nxt_st.started    = 1'b1;
        end
      end else if (cont_ok) begin
        nxt_st.step = st_ff.step + BURST_ONE;                           // RL15
        if (st_ff.burst == LWSP_RD) begin
          nxt_st.s1.rd   = 1'b1;                                        // RL13
          nxt_st.s1.addr = nxt_addr(st_ff);
        end else if (st_ff.burst == LWSP_WR) begin
          nxt_st.s1.wr      = ~&i_byte_lane_n;                          // RL9
          nxt_st.s1.lanes_n = i_byte_lane_n;
          nxt_st.s1.addr    = nxt_addr(st_ff);
        end
      end
      // Pipelined output register captures read of previous access
      if (st_ff.s1.rd && !flow) begin
        nxt_st.rd_reg = mem_ff[st_ff.s1.addr];                          // RL6
        nxt_st.rd_vld = 1'b1;
      end
    end
    if (zz_hold) begin
      nxt_st.rd_vld = 1'b0;
    end
  end

  // Address used by a continue cycle: the step after the current one
  function automatic logic [ADDR_W-1:0] nxt_addr(input lwsp_state_t s);
    nxt_addr = {s.base[ADDR_W-1:2],
                lwsp_burst_addr(s.base[1:0], s.step + BURST_ONE, i_linear_order_n)};
  endfunction : nxt_addr

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '0;                                                      // RL19
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Memory has no reset; per-lane write on the late-data edge
  always_ff @(posedge i_sys_clk) begin
    if (!frozen && wr_slot.wr) begin
      for (int l = 0; l < LANES; l++) begin
        if (!wr_slot.lanes_n[l]) begin                                  // RL8
          mem_ff[wr_slot.addr][l*LANE_W +: LANE_W] <= i_dq[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Flow-through reads come straight from the array after the address edge
  assign rd_word = flow ? mem_ff[st_ff.s1.addr] : st_ff.rd_reg;         // RL11

  always_comb begin
    o_dq    = rd_word;
    o_dq_oe = 1'b0;
    if (st_ff.started && !zz_hold && !i_out_en_n) begin                 // RL16 RL19 RL22
      o_dq_oe = flow ? st_ff.s1.rd : st_ff.rd_vld;                      // RL17 RL18
    end
  end

  assign o_asleep = st_ff.asleep;

  chk_gate_holds_addr: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL1
    (i_clk_gate_n && !zz_hold) |=> ($stable(st_ff.base) && $stable(st_ff.step)))
    else $error("address moved under clock gate");

  chk_pipe_read_lat: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL6
    (!flow && !frozen && st_ff.s1.rd && !i_clk_gate_n) |=> st_ff.rd_vld || zz_hold)
    else $error("pipelined read missed output register");

  chk_flow_drive: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL11
    (flow && st_ff.s1.rd && !i_out_en_n && !zz_hold && st_ff.started) |-> o_dq_oe)
    else $error("flow-through read not driven");

  chk_abort_float: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL9
    (!frozen && is_load && selected && !i_write_n && &i_byte_lane_n) |=> !st_ff.s1.wr)
    else $error("write abort still wrote");

  // A stall right after the deselect legally keeps an older read on the bus
  chk_desel_float: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL4
    (!frozen && is_load && !selected) ##1 !frozen |=> (flow || !o_dq_oe))
    else $error("deselect left bus driven");

  chk_cont_step: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL15
    (!frozen && cont_ok) |=> st_ff.step == $past(st_ff.step) + BURST_ONE)
    else $error("burst counter did not step");

  chk_dummy_read: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL16
    i_out_en_n |-> !o_dq_oe)
    else $error("dummy read drove bus");

  chk_sleep_float: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL22
    zz_sync ##1 zz_sync |=> o_asleep && !o_dq_oe)
    else $error("sleep not entered after two cycles");

  chk_write_no_drive: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL17
    (st_ff.burst == LWSP_WR && !st_ff.rd_vld && !st_ff.s1.rd) |-> !o_dq_oe)
    else $error("bus driven during write");

  // Steps of an access as seen at one edge; properties below chain them
  sequence s_live;
    !i_clk_gate_n && !zz_hold;
  endsequence : s_live

  sequence s_gated;
    i_clk_gate_n && !zz_hold;
  endsequence : s_gated

  sequence s_rd_load;
    !frozen && is_load && selected && i_write_n;
  endsequence : s_rd_load

  sequence s_wr_load;
    !frozen && is_load && selected && !i_write_n && !(&i_byte_lane_n);
  endsequence : s_wr_load

  // Load cycles fill the first slot from the pins
  chk_rd_load_slot: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL5
    s_rd_load |=> (st_ff.s1.rd && st_ff.burst == LWSP_RD && st_ff.s1.addr == $past(i_addr)))
    else $error("read load not registered");

  chk_wr_load_slot: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL7
    s_wr_load |=> (st_ff.s1.wr && st_ff.s1.addr == $past(i_addr)
                   && st_ff.s1.lanes_n == $past(i_byte_lane_n)))
    else $error("write load not registered");

  chk_load_base: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL3
    (!frozen && is_load) |=> (st_ff.step == BURST_INIT && st_ff.base == $past(i_addr)))
    else $error("load did not take external address");

  chk_desel_empty: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL4
    (!frozen && is_load && !selected) |=> (st_ff.burst == LWSP_DESEL
                                            && !st_ff.s1.rd && !st_ff.s1.wr))
    else $error("deselect started an access");

  // Late write: the slot must still be live when its data edge comes
  chk_pipe_wr_slot: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL10
    s_wr_load ##1 s_live |=> st_ff.s2.wr)
    else $error("pipelined write lost before data edge");

  chk_flow_wr_slot: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL12
    s_wr_load ##0 flow |=> wr_slot.wr)
    else $error("flow-through write not due on next edge");

  chk_pipe_rd_out: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL6
    s_rd_load ##0 !flow ##1 s_live |=> st_ff.rd_vld)
    else $error("pipelined read not in output register");

  chk_flow_rd_out: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL11
    s_rd_load ##0 flow |=> (st_ff.s1.rd && st_ff.started))
    else $error("flow-through read not presented");

  chk_pipe_dq_reg: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL6
    !flow |-> o_dq == st_ff.rd_reg)
    else $error("pipelined data bypassed register");

  chk_flow_dq_array: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL11
    flow |-> o_dq == mem_ff[st_ff.s1.addr])
    else $error("flow-through data not from array");

  // Burst continue keeps the type and steps the counter address
  chk_cont_repeat: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL13
    (!frozen && cont_ok && st_ff.burst == LWSP_RD) |=> (st_ff.s1.rd && st_ff.burst == LWSP_RD))
    else $error("read burst not continued");

  chk_cont_addr: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL13 RL20
    (!frozen && cont_ok && st_ff.burst != LWSP_DESEL) |=> st_ff.s1.addr == cur_addr)
    else $error("continue used wrong address");

  chk_cont_ignored: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL14
    (!frozen && is_cont && st_ff.burst == LWSP_IDLE)
      |=> (!st_ff.s1.rd && !st_ff.s1.wr && $stable(st_ff.step)))
    else $error("continue with no prior load acted");

  chk_step_wrap: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL15 RL20
    (!frozen && cont_ok && &st_ff.step) |=> st_ff.step == BURST_INIT)
    else $error("burst counter did not wrap");

  // Stall keeps everything in flight, including the read register
  chk_gate_slots: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL1 RL18
    s_gated |=> ($stable(st_ff.s1) && $stable(st_ff.s2) && $stable(st_ff.rd_vld)))
    else $error("stall moved an access");

  chk_gate_rd_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL18
    s_gated |=> $stable(st_ff.rd_reg))
    else $error("stall changed read register");

  // Lane enables: lowest lane written when enabled, top lane kept when not
  chk_lane_written: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL8
    (!frozen && wr_slot.wr && !wr_slot.lanes_n[0])
      |=> mem_ff[$past(wr_slot.addr)][LANE_W-1:0] == $past(i_dq[LANE_W-1:0]))
    else $error("enabled lane not written");

  chk_lane_kept: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL8
    (!frozen && wr_slot.wr && wr_slot.lanes_n[LANES-1])
      |=> mem_ff[$past(wr_slot.addr)][DATA_W-1 -: LANE_W]
          == $past(mem_ff[wr_slot.addr][DATA_W-1 -: LANE_W]))
    else $error("disabled lane overwritten");

  // Power-up: nothing drives until the first access
  chk_power_up_float: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL19
    !st_ff.started |-> !o_dq_oe)
    else $error("bus driven before first access");

  chk_started_sticks: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL19
    st_ff.started |=> st_ff.started)
    else $error("started flag dropped");

  // Sleep needs two edges of request, wakes at once and freezes state
  chk_sleep_entry: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL22
    $rose(st_ff.asleep) |-> ($past(zz_sync) && $past(zz_sync, 2)))
    else $error("sleep entered too early");

  chk_wake_prompt: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL22
    !zz_sync |=> !st_ff.asleep)
    else $error("sleep held after request dropped");

  chk_asleep_float: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL22
    st_ff.asleep |-> !o_dq_oe)
    else $error("bus driven while asleep");

  chk_sleep_freeze: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RL22
    (st_ff.asleep && zz_sync) |=> ($stable(st_ff.base) && $stable(st_ff.burst)
                                    && $stable(st_ff.s1)))
    else $error("state moved while asleep");
endmodule : lwsp_port

// File: tb/lwsp_ctrl_model.sv
// Controller model: launches late-write data toward the port
module lwsp_ctrl_model
  import lwsp_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_clk_gate_n,
  input  wire logic              i_flowthru_sel_n,
  input  wire logic              i_wr,
  input  wire logic [DATA_W-1:0] i_wdata,
  output logic      [DATA_W-1:0] o_dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic              wr_ff;
  logic [DATA_W-1:0] wd_ff;
  initial begin
    o_dq  = '0;
    wr_ff = 1'b0;
  end
  // Idle bus toggles every ungated cycle so a late or early sample never sees the right word
  always @(posedge i_sys_clk) begin
    if (!i_clk_gate_n) begin
      wr_ff <= i_wr;
      wd_ff <= i_wdata;
      if (!i_flowthru_sel_n) o_dq <= i_wr ? i_wdata : ~o_dq;
      else o_dq <= wr_ff ? wd_ff : ~o_dq;
    end
  end
endmodule : lwsp_ctrl_model

// File: tb/lwsp_port_tb.sv
// Testbench: scoreboard model of the port compared with the design
module lwsp_port_tb
  import lwsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, rst, gate_n, sla, shi, slc, wr_n, step, oe_n, lin_n, flow_n, slp;
  logic              dq_oe, asleep, p_wr;
  logic [LANES-1:0]  lanes_n;
  logic [ADDR_W-1:0] addr, ba;
  logic [DATA_W-1:0] dq_in, dq_out, p_wd;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] e_dq [4096];
  bit                e_oe [4096];
  bit                e_dum [4096];
  logic [1:0]        bn;
  int                error_cnt, tests_run, cyc, bk, lat;

  always #2 clk = ~clk;

  lwsp_port uut (.i_sys_clk(clk), .i_rst(rst), .i_clk_gate_n(gate_n), .i_chip_sel_lo_a(sla),
    .i_chip_sel_hi(shi), .i_chip_sel_lo_c(slc), .i_write_n(wr_n), .i_byte_lane_n(lanes_n),
    .i_burst_step_load(step), .i_addr(addr), .i_out_en_n(oe_n), .i_linear_order_n(lin_n),
    .i_flowthru_sel_n(flow_n), .i_sleep_req(slp), .i_dq(dq_in), .o_dq(dq_out),
    .o_dq_oe(dq_oe), .o_asleep(asleep));
  lwsp_ctrl_model ctrl (.i_sys_clk(clk), .i_clk_gate_n(gate_n), .i_flowthru_sel_n(flow_n),
    .i_wr(p_wr), .i_wdata(p_wd), .o_dq(dq_in));

  task automatic cmp_bit(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_dq(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t read data got %h exp %h", $time, got, exp);
    end
  endtask : cmp_dq

  // Index counts only ungated edges, so held outputs are checked against held values
  task automatic tick();
    @(posedge clk);
    if (gate_n === 1'b0) cyc++;
    @(negedge clk);
    oe_n = e_dum[cyc];
    #1;
    cmp_bit(dq_oe, e_oe[cyc] & ~e_dum[cyc], "drive enable");
    if (e_oe[cyc] && !e_dum[cyc]) cmp_dq(dq_out, e_dq[cyc]);
  endtask : tick

  // k: 0 read, 1 write, 2 deselect, 3 continue; g presents it first on a gated edge
  task automatic cmd(input int k, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln,
                     input bit dum, input bit g);
    logic [DATA_W-1:0] w;
    logic [ADDR_W-1:0] c;
    w = DATA_W'({$urandom(), $urandom()});
    step = (k == 3);
    {sla, shi, slc} = (k == 3) ? 3'($urandom()) : (k == 2) ? 3'h7 : 3'h2;
    wr_n = (k == 3) ? 1'($urandom()) : (k != 1);
    addr = (k == 3) ? ADDR_W'($urandom()) : a;
    lanes_n = ln;
    if (k != 3) begin
      bk = k;
      ba = a;
      bn = 2'h0;
    end else bn = bn + 2'h1;
    c = {ba[ADDR_W-1:2], lin_n ? ba[1:0] ^ bn : ba[1:0] + bn};
    p_wr = (bk == 1);
    p_wd = w;
    for (int l = 0; l < LANES; l++)
      if (bk == 1 && !ln[l]) mem[c][l*LANE_W +: LANE_W] = w[l*LANE_W +: LANE_W];
    if (bk == 0) begin
      e_oe[cyc+lat] = 1'b1;
      e_dq[cyc+lat] = mem[c];
      e_dum[cyc+lat] = dum;
    end
    gate_n = g;
    if (g) begin
      tick();
      gate_n = 1'b0;
    end
    tick();
  endtask : cmd

  task automatic run(input logic f, input logic l);
    logic [ADDR_W-1:0] a;
    rst = 1'b1;
    flow_n = f;
    lin_n = l;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    bk = 2;
    lat = f ? 2 : 1;
    a = ADDR_W'($urandom());
    cmd(3, a, 4'h0, 0, 0);
    cmd(2, a, 4'h0, 0, 0);
    cmd(3, a, 4'h0, 0, 0);
    cmd(1, a, 4'h0, 0, 0);
    cmd(3, a, 4'h0, 0, 1);
    repeat (2) cmd(3, a, 4'h0, 0, 0);
    cmd(1, a, 4'hF, 0, 0);
    repeat (3) cmd(3, a, LANES'($urandom()), 0, 0);
    cmd(0, a, 4'h0, 0, 0);
    cmd(3, a, 4'h0, 0, 1);
    cmd(3, a, 4'h0, 1, 0);
    cmd(3, a, 4'h0, 0, 0);
    cmd(2, a, 4'h0, 0, 0);
    repeat (3) cmd(3, a, 4'h0, 0, 0);
    $display("test done flow_n=%0b lin_n=%0b", f, l);
  endtask : run

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  initial begin
    #20000;
    error_cnt++;
    close_out();
  end

  initial begin
    int i;
    clk = 1'b0;
    rst = 1'b1;
    gate_n = 1'b0;
    {sla, shi, slc} = 3'h7;
    {wr_n, step, oe_n, lin_n, flow_n, slp, p_wr} = 7'h08;
    lanes_n = '1;
    addr = '0;
    p_wd = '0;
    void'($urandom(32'h1f5c));
    for (i = 0; i < 4; i++) run(i[0], i[1]);
    slp = 1'b1;
    for (i = 0; i < 10 && asleep !== 1'b1; i++) tick();
    cmp_bit(asleep, 1'b1, "sleep entry");
    slp = 1'b0;
    for (i = 0; i < 10 && asleep !== 1'b0; i++) tick();
    cmp_bit(asleep, 1'b0, "sleep exit");
    $display("test done sleep");
    close_out();
  end
endmodule : lwsp_port_tb
